// ===== verilog/sawdg_top.sv
`timescale 1ns/1ps
module sawdg_top
    import sawdg_pkg::*;
(
    input  wire logic           clk_sys,
    input  wire logic           rst,
    input  wire sawdg_bus_req_t bus_req,
    output logic [DATA_W-1:0]   bus_rdata_r,
    input  wire logic           low_speed_osc,
    input  wire logic           hw_mode_option,
    input  wire logic           stop_mode,
    input  wire logic           osc_off_in_stop,
    output logic                sys_reset_req_r,
    output logic                irq_r
);

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic logic [7:0] div_limit(input logic [DIVSEL_W-1:0] sel);
        case (sel)
            3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5: div_limit = 8'((DIV_LIMIT_MIN + 8'h01) << sel) - 8'h01;
            default: div_limit = DIV_LIMIT_MAX;
        endcase
    endfunction : div_limit

    sawdg_state_t        state_r;
    logic [COUNT_W-1:0]  count_r;
    logic [COUNT_W-1:0]  reload_field_r;
    logic [COUNT_W-1:0]  threshold_r;
    logic [DIVSEL_W-1:0] divider_field_r;
    logic                irq_sel_r;
    logic                unlock_r;
    logic                div_pend_r;
    logic                reload_update_pending_r;
    logic [IRQ_W-1:0]    irq_stat_r;
    logic [IRQ_W-1:0]    irq_mask_r;
    logic                strap_done_r;
    logic                hw_mode_r;
    logic                osc_s1_r;
    logic                osc_s2_r;
    logic                osc_s3_r;
    logic                osc_lvl_r;
    logic [7:0]          presc_r;

    logic             wr_key;
    logic [15:0]      key_val;
    logic             key_start;
    logic             key_feed;
    logic             wr_prot;
    logic             strap_start;
    logic             osc_rise;
    logic             osc_gate;
    logic             osc_tick;
    logic             count_tick;
    logic             at_zero;
    logic             at_end;
    logic [COUNT_W-1:0] count_dec;
    logic [IRQ_W-1:0] irq_evt;

    assign wr_key      = bus_req.wr && hit(bus_req.addr, OFF_UNLOCK_FEED_WORD);
    assign key_val     = bus_req.wdata[15:0];
    assign key_start   = wr_key && (key_val == KEY_START);
    assign key_feed    = wr_key && (key_val == KEY_FEED);
    assign wr_prot     = bus_req.wr && unlock_r;
    assign strap_start = !strap_done_r && hw_mode_option;
    assign at_zero     = (count_r == '0);
    // expiry on the tick that reaches zero; a reload of zero still waits one tick
    assign at_end      = (count_r <= 12'h001);
    assign count_dec   = count_r - 12'h001;

    // slow oscillator sampled as a pin; counting steps on its rising edges, and a feed write clears the prescaler
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            // reset high: a slow clock parked high gives no false edge
            osc_s1_r  <= 1'b1;
            osc_s2_r  <= 1'b1;
            osc_s3_r  <= 1'b1;
            osc_lvl_r <= 1'b1;
        end else begin
            osc_s1_r <= low_speed_osc;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
            if (osc_s2_r == osc_s3_r) begin
                osc_lvl_r <= osc_s3_r;
            end
        end
    end

    assign osc_rise   = osc_s2_r && osc_s3_r && !osc_lvl_r;
    // hardware mode ignores the stop-mode oscillator shutdown
    assign osc_gate   = stop_mode && osc_off_in_stop && !hw_mode_r;
    assign osc_tick   = osc_rise && !osc_gate;
    assign count_tick = osc_tick && (state_r == ST_COUNT) && (presc_r == div_limit(divider_field_r));

    // prescaler
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            presc_r <= 8'h00;
        end else if (state_r != ST_COUNT || key_feed) begin
            presc_r <= 8'h00;
        end else if (osc_tick) begin
            if (presc_r >= div_limit(divider_field_r)) begin
                presc_r <= 8'h00;
            end else begin
                presc_r <= presc_r + 8'h01;
            end
        end
    end

    // strap caught one cycle after reset release
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            strap_done_r <= 1'b0;
            hw_mode_r    <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            hw_mode_r    <= hw_mode_option;
        end
    end

    // state machine
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (key_start || strap_start) begin
                        state_r <= ST_COUNT;
                    end
                end
                ST_COUNT: begin
                    if (count_tick && at_end && !irq_sel_r) begin
                        state_r <= ST_FIRED;
                    end
                end
                ST_FIRED: state_r <= ST_FIRED;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // reset request held until the system reset arrives
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sys_reset_req_r <= 1'b0;
        end else if (state_r == ST_COUNT && count_tick && at_end && !irq_sel_r) begin
            sys_reset_req_r <= 1'b1;
        end
    end

    // down counter
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count_r <= RST_COUNT;
        end else if ((key_start || strap_start) && state_r == ST_IDLE) begin
            count_r <= START_COUNT;
        end else if (key_feed && state_r == ST_COUNT) begin
            count_r <= reload_field_r;
        end else if (count_tick) begin
            if (at_end && irq_sel_r) begin
                count_r <= reload_field_r;
            end else if (!at_zero) begin
                count_r <= count_dec;
            end
        end
    end

    // unlock sequence
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            unlock_r <= 1'b0;
        end else if (wr_key) begin
            unlock_r <= (key_val == KEY_UNLOCK);
        end
    end

    // protected configuration
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            divider_field_r <= RST_DIVSEL;
            reload_field_r  <= RST_RELOAD;
            threshold_r     <= RST_THRESHOLD;
            irq_sel_r       <= 1'b0;
        end else if (wr_prot) begin
            if (hit(bus_req.addr, OFF_CLOCK_DIVIDER_SEL)) begin
                divider_field_r <= bus_req.wdata[DIVSEL_W-1:0];
            end
            if (hit(bus_req.addr, OFF_RELOAD_VALUE)) begin
                reload_field_r <= bus_req.wdata[COUNT_W-1:0];
            end
            if (hit(bus_req.addr, OFF_INTERRUPT_THRESHOLD)) begin
                threshold_r <= bus_req.wdata[COUNT_W-1:0];
            end
            if (hit(bus_req.addr, OFF_WATCHDOG_CONTROL)) begin
                irq_sel_r <= bus_req.wdata[CTRL_IRQ_SEL_BIT];
            end
        end
    end

    // update pending: set wins over the slow-domain clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_pend_r              <= 1'b0;
            reload_update_pending_r <= 1'b0;
        end else begin
            div_pend_r <= (div_pend_r && !osc_tick) ||
                          (wr_prot && hit(bus_req.addr, OFF_CLOCK_DIVIDER_SEL));
            reload_update_pending_r <= (reload_update_pending_r && !osc_tick) ||
                                       (wr_prot && hit(bus_req.addr, OFF_RELOAD_VALUE));
        end
    end

    // interrupt events
    assign irq_evt[IRQ_EXPIRE_BIT] = count_tick && at_end && irq_sel_r;
    assign irq_evt[IRQ_THRESH_BIT] = count_tick && !at_end && irq_sel_r && (count_dec == threshold_r);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_stat_r <= '0;
        end else if (bus_req.rd && hit(bus_req.addr, OFF_IRQ_STATUS)) begin
            irq_stat_r <= irq_evt;
        end else begin
            irq_stat_r <= irq_stat_r | irq_evt;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_mask_r <= '0;
        end else if (bus_req.wr && hit(bus_req.addr, OFF_IRQ_MASK)) begin
            irq_mask_r <= bus_req.wdata[IRQ_W-1:0];
        end
    end

    // one cycle behind the status bit, keeps the output a pure flop
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    // read port
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bus_rdata_r <= '0;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                OFF_CLOCK_DIVIDER_SEL:   bus_rdata_r <= {29'h0, divider_field_r};
                OFF_RELOAD_VALUE:        bus_rdata_r <= {20'h0, reload_field_r};
                OFF_UPDATE_STATUS:       bus_rdata_r <= {30'h0, reload_update_pending_r, div_pend_r};
                OFF_WATCHDOG_CONTROL:    bus_rdata_r <= {31'h0, irq_sel_r};
                OFF_INTERRUPT_THRESHOLD: bus_rdata_r <= {20'h0, threshold_r};
                OFF_CURRENT_COUNT:       bus_rdata_r <= {20'h0, count_r};
                OFF_IRQ_STATUS:          bus_rdata_r <= {30'h0, irq_stat_r};
                OFF_IRQ_MASK:            bus_rdata_r <= {30'h0, irq_mask_r};
                default:                 bus_rdata_r <= '0;
            endcase
        end else begin
            bus_rdata_r <= '0;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_start_load: assert property (key_start && state_r == ST_IDLE |=> count_r == START_COUNT && state_r == ST_COUNT)
        else $error("start word did not load the counter");
    a_reset_fire: assert property (state_r == ST_COUNT && count_tick && at_end && !irq_sel_r |=> sys_reset_req_r)
        else $error("reset request missing at expiry");
    a_irq_no_reset: assert property (count_tick && at_end && irq_sel_r && !sys_reset_req_r
        |=> !sys_reset_req_r && irq_stat_r[IRQ_EXPIRE_BIT])
        else $error("interrupt mode expiry handled wrongly");
    a_feed_reload: assert property (key_feed && state_r == ST_COUNT |=> count_r == $past(reload_field_r))
        else $error("feed did not reload the counter");
    a_locked_div: assert property (bus_req.wr && !unlock_r && hit(bus_req.addr, OFF_CLOCK_DIVIDER_SEL)
        |=> $stable(divider_field_r))
        else $error("locked divider register was written");
    a_unlock_cancel: assert property (wr_key && key_val != KEY_UNLOCK |=> !unlock_r and (!wr_key |=> !unlock_r))
        else $error("unlock not cancelled by other key");
    a_key_readzero: assert property (bus_req.rd && hit(bus_req.addr, OFF_UNLOCK_FEED_WORD) |=> bus_rdata_r == '0)
        else $error("key register read not zero");
    a_count_dec: assert property (count_tick && !at_end && !wr_key |=> count_r == $past(count_dec))
        else $error("counter did not step down by one");
    a_hw_start: assert property (strap_start |=> state_r == ST_COUNT && hw_mode_r ##1 state_r != ST_IDLE)
        else $error("hardware mode did not start");
    a_stop_hold: assert property (state_r == ST_COUNT && osc_gate && !wr_key |=> $stable(count_r))
        else $error("counter moved with oscillator stopped");
    a_pend_clear: assert property (reload_update_pending_r && osc_tick && !bus_req.wr |=> !reload_update_pending_r)
        else $error("reload pending not cleared");
    a_irq_output: assert property (##1 irq_r == $past(|(irq_stat_r & irq_mask_r)))
        else $error("interrupt output does not follow status");

    // guards on threshold, reset hold, idle count, lock, pending, mask and readback paths
    a_thresh_evt: assert property (count_tick && !at_end && irq_sel_r && count_dec == threshold_r
        |=> irq_stat_r[IRQ_THRESH_BIT])
        else $error("threshold event not recorded");
    a_reset_hold: assert property (sys_reset_req_r |=> sys_reset_req_r)
        else $error("reset request dropped");
    a_idle_still: assert property (state_r == ST_IDLE && !key_start && !strap_start |=> $stable(count_r))
        else $error("counter moved before start");
    a_locked_rld: assert property (bus_req.wr && !unlock_r && hit(bus_req.addr, OFF_RELOAD_VALUE)
        |=> $stable(reload_field_r))
        else $error("locked reload register was written");
    a_locked_thr: assert property (bus_req.wr && !unlock_r && hit(bus_req.addr, OFF_INTERRUPT_THRESHOLD)
        |=> $stable(threshold_r))
        else $error("locked threshold register was written");
    a_locked_ctrl: assert property (bus_req.wr && !unlock_r && hit(bus_req.addr, OFF_WATCHDOG_CONTROL)
        |=> $stable(irq_sel_r))
        else $error("locked control bit was written");
    a_count_read: assert property (bus_req.rd && hit(bus_req.addr, OFF_CURRENT_COUNT)
        |=> bus_rdata_r == {20'h0, $past(count_r)})
        else $error("count readback wrong");
    a_stat_clear: assert property (bus_req.rd && hit(bus_req.addr, OFF_IRQ_STATUS) && irq_evt == '0
        |=> irq_stat_r == '0)
        else $error("status read did not clear");
    a_pend_set: assert property (wr_prot && hit(bus_req.addr, OFF_RELOAD_VALUE) |=> reload_update_pending_r)
        else $error("reload pending not set");
    a_mask_off: assert property (irq_mask_r == '0 |=> !irq_r)
        else $error("masked interrupt reached output");
    a_rdata_idle: assert property (!bus_req.rd |=> bus_rdata_r == '0)
        else $error("read data not zero outside read");
    a_feed_lock: assert property (key_feed |=> !unlock_r)
        else $error("feed did not relock");

endmodule : sawdg_top

// ===== verilog/sawdg_pkg.sv
package sawdg_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int COUNT_W = 12;
    localparam int DIVSEL_W = 3;

    // register offsets
    localparam logic [7:0] OFF_UNLOCK_FEED_WORD    = 8'h00;
    localparam logic [7:0] OFF_CLOCK_DIVIDER_SEL   = 8'h04;
    localparam logic [7:0] OFF_RELOAD_VALUE        = 8'h08;
    localparam logic [7:0] OFF_UPDATE_STATUS       = 8'h0C;
    localparam logic [7:0] OFF_WATCHDOG_CONTROL    = 8'h10;
    localparam logic [7:0] OFF_INTERRUPT_THRESHOLD = 8'h14;
    localparam logic [7:0] OFF_CURRENT_COUNT       = 8'h18;
    localparam logic [7:0] OFF_IRQ_STATUS          = 8'h1C;
    localparam logic [7:0] OFF_IRQ_MASK            = 8'h20;

    // key words
    localparam logic [15:0] KEY_START  = 16'hCCCC;
    localparam logic [15:0] KEY_FEED   = 16'hAAAA;
    localparam logic [15:0] KEY_UNLOCK = 16'h5555;

    // field positions
    localparam int CTRL_IRQ_SEL_BIT     = 0;
    localparam int STAT_DIV_PEND_BIT    = 0;
    localparam int STAT_RELOAD_PEND_BIT = 1;
    localparam int IRQ_EXPIRE_BIT       = 0;
    localparam int IRQ_THRESH_BIT       = 1;
    localparam int IRQ_W                = 2;

    // reset values
    localparam logic [COUNT_W-1:0]  RST_RELOAD    = 12'hFFF;
    localparam logic [COUNT_W-1:0]  RST_THRESHOLD = 12'hFFF;
    localparam logic [COUNT_W-1:0]  RST_COUNT     = 12'h001;
    localparam logic [COUNT_W-1:0]  START_COUNT   = 12'hFFF;
    localparam logic [DIVSEL_W-1:0] RST_DIVSEL    = 3'h0;

    // prescale count limits (divide by 4 << field, capped at 256)
    localparam logic [7:0] DIV_LIMIT_MIN = 8'h03;
    localparam logic [7:0] DIV_LIMIT_MAX = 8'hFF;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } sawdg_bus_req_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_COUNT = 2'b01,
        ST_FIRED = 2'b10
    } sawdg_state_t;

endpackage : sawdg_pkg

// ===== testbench/sawdg_tb.sv
`timescale 1ns/1ps
module sawdg_tb;
    import sawdg_pkg::*;
    logic           clk_sys         = 1'b0;
    logic           rst             = 1'b1;
    sawdg_bus_req_t bus_req         = '0;
    logic [31:0]    bus_rdata_r;
    logic           low_speed_osc   = 1'b0;
    logic           hw_mode_option  = 1'b0;
    logic           stop_mode       = 1'b0;
    logic           osc_off_in_stop = 1'b0;
    logic           sys_reset_req_r;
    logic           irq_r;
    logic           osc_run         = 1'b0;
    logic [3:0]     osc_div         = 4'h0;
    int             n_edge          = 0;
    int             n_mismatch      = 0;
    int             total_checks    = 0;
    int             seed            = 32'he725;
    logic           rd_prev         = 1'b0;
    logic [31:0]    exp_q[$];

    sawdg_top dut (
        .clk_sys         (clk_sys),
        .rst             (rst),
        .bus_req         (bus_req),
        .bus_rdata_r     (bus_rdata_r),
        .low_speed_osc   (low_speed_osc),
        .hw_mode_option  (hw_mode_option),
        .stop_mode       (stop_mode),
        .osc_off_in_stop (osc_off_in_stop),
        .sys_reset_req_r (sys_reset_req_r),
        .irq_r           (irq_r)
    );

    always #20 clk_sys = ~clk_sys;

    // slow clock: 16 system cycles a period, frozen when idle like a gated oscillator
    always @(posedge clk_sys) begin
        if (osc_run) begin
            osc_div       <= osc_div + 4'h1;
            low_speed_osc <= (osc_div == 4'h7) ? 1'b1 : ((osc_div == 4'hF) ? 1'b0 : low_speed_osc);
            if (osc_div == 4'h7) n_edge <= n_edge + 1;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%08h exp=%08h", $time, got, exp);
        end
    endtask : chk

    // read data stand only in the cycle after the strobe
    always @(posedge clk_sys) rd_prev <= bus_req.rd;
    always @(negedge clk_sys) if (rd_prev) chk(bus_rdata_r, exp_q.pop_front());

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        bus_req.wr    <= 1'b1;
        @(posedge clk_sys);
        bus_req.wr    <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        bus_req.addr <= a;
        bus_req.rd   <= 1'b1;
        exp_q.push_back(exp);
        @(posedge clk_sys);
        bus_req.rd   <= 1'b0;
    endtask : rd

    task pw(input logic [7:0] a, input logic [31:0] d);
        wr(OFF_UNLOCK_FEED_WORD, {16'h0000, KEY_UNLOCK});
        wr(a, d);
    endtask : pw

    task do_reset;
        rst <= 1'b1;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
    endtask : do_reset

    task feed;
        wr(OFF_UNLOCK_FEED_WORD, {16'h0000, KEY_FEED});
    endtask : feed

    // slow edges from start until the chosen output rises
    task run_until(input logic use_irq, input int exp);
        int st;
        int i;
        st = n_edge;
        osc_run <= 1'b1;
        for (i = 0; i < 20000 && ((use_irq ? irq_r : sys_reset_req_r) !== 1'b1); i++) @(posedge clk_sys);
        osc_run <= 1'b0;
        chk(32'(n_edge - st), 32'(exp));
    endtask : run_until

    task run_fixed;
        osc_run <= 1'b1;
        repeat (640) @(posedge clk_sys);
        osc_run <= 1'b0;
        // let the last slow edge clear the synchroniser
        repeat (6) @(posedge clk_sys);
    endtask : run_fixed

    task report_and_stop;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    initial begin
        #(40 * 60000);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        logic [7:0]  ad[8];
        logic [31:0] ev[8];
        logic [31:0] rk;
        logic [31:0] rv;
        int          f;
        ad = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h24};
        ev = '{32'h0, 32'h0, 32'hFFF, 32'h0, 32'h0, 32'hFFF, 32'h1, 32'h0};
        rk = $random(seed);
        rv = $random(seed);
        if (rk[15:0] == KEY_UNLOCK) rk[0] = ~rk[0];
        do_reset();
        for (f = 0; f < 8; f++) rd(ad[f], ev[f]);
        wr(OFF_RELOAD_VALUE, rv & 32'hFFF);
        wr(OFF_WATCHDOG_CONTROL, 32'h1);
        wr(OFF_UNLOCK_FEED_WORD, {16'h0000, KEY_UNLOCK});
        wr(OFF_UNLOCK_FEED_WORD, rk);
        wr(OFF_RELOAD_VALUE, rv & 32'hFFF);
        rd(OFF_RELOAD_VALUE, 32'hFFF);
        rd(OFF_WATCHDOG_CONTROL, 32'h0);
        wr(OFF_UNLOCK_FEED_WORD, {16'h0000, KEY_START});
        rd(OFF_CURRENT_COUNT, 32'hFFF);
        wr(OFF_IRQ_MASK, 32'h1);
        pw(OFF_WATCHDOG_CONTROL, 32'h1);
        for (f = 0; f < 8; f++) begin
            pw(OFF_CLOCK_DIVIDER_SEL, 32'(f));
            pw(OFF_RELOAD_VALUE, 32'h2);
            rd(OFF_UPDATE_STATUS, 32'h3);
            rd(OFF_CLOCK_DIVIDER_SEL, 32'(f));
            feed();
            rd(OFF_CURRENT_COUNT, 32'h2);
            run_until(1'b1, (4 << ((f > 5) ? 6 : f)) * 2);
            rd(OFF_UPDATE_STATUS, 32'h0);
            rd(OFF_IRQ_STATUS, 32'h1);
            repeat (3) @(posedge clk_sys);
            chk({31'h0, irq_r}, 32'h0);
        end
        wr(OFF_IRQ_MASK, 32'h0);
        pw(OFF_CLOCK_DIVIDER_SEL, 32'h0);
        feed();
        run_fixed();
        chk({31'h0, irq_r}, 32'h0);
        rd(OFF_IRQ_STATUS, 32'h1);
        wr(OFF_IRQ_MASK, 32'h2);
        pw(OFF_INTERRUPT_THRESHOLD, 32'h1);
        feed();
        run_until(1'b1, 4);
        rd(OFF_IRQ_STATUS, 32'h2);
        // oscillator gated in stop: count must freeze
        stop_mode       <= 1'b1;
        osc_off_in_stop <= 1'b1;
        feed();
        run_fixed();
        rd(OFF_CURRENT_COUNT, 32'h2);
        stop_mode       <= 1'b0;
        osc_off_in_stop <= 1'b0;
        pw(OFF_WATCHDOG_CONTROL, 32'h0);
        pw(OFF_RELOAD_VALUE, 32'h3);
        feed();
        run_until(1'b0, 12);
        rd(OFF_CURRENT_COUNT, 32'h0);
        chk({31'h0, irq_r}, 32'h0);
        hw_mode_option <= 1'b1;
        do_reset();
        rd(OFF_CURRENT_COUNT, 32'hFFF);
        chk({31'h0, sys_reset_req_r}, 32'h0);
        run_fixed();
        rd(OFF_CURRENT_COUNT, 32'hFF5);
        repeat (4) @(posedge clk_sys);
        report_and_stop();
    end
endmodule : sawdg_tb
